// ==== shared/gioc_pkg.sv ====
/*
 File: package for the pin logic cell, holding the modes, the pull codes and the reset values.
 Assumes: it is compiled before every design file that imports it.
*/
package gioc_pkg;

    // ------------------------------------------------------------
    // Pin modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        GIOC_MODE_UNUSED,
        GIOC_MODE_INPUT,
        GIOC_MODE_OUTPUT,
        GIOC_MODE_BIDIR,
        GIOC_MODE_CLKOUT
    } gioc_mode_e;

    // ------------------------------------------------------------
    // Pull codes driven to the pad buffer
    // ------------------------------------------------------------
    localparam logic [1:0] GIOC_PULL_NONE = 2'h0;
    localparam logic [1:0] GIOC_PULL_UP = 2'h1;
    localparam logic [1:0] GIOC_PULL_DOWN = 2'h2;

    // ------------------------------------------------------------
    // Reset values of the cell registers
    // ------------------------------------------------------------
    localparam logic GIOC_DATA_RST = 1'h0;
    localparam logic GIOC_OE_RST = 1'h0;

endpackage : gioc_pkg

// ==== hw/gioc_edge_reg.sv ====
/*
 File: one cell register with a selectable rising or falling capture edge.
 Assumes: clk is a clock of the cell; reset is synchronous to mclk but is
 also honoured on whichever edge the register uses.
*/
`timescale 1ns/1ps
module gioc_edge_reg
    import gioc_pkg::*;
(
    input wire logic clk, // Capture clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic fall_sel, // 1 selects the falling edge
    input wire logic d, // Data in
    output logic q // Registered data out
);

    // ------------------------------------------------------------
    // Rise and fall flops, chosen by the edge option
    // ------------------------------------------------------------
    logic rise_q;
    logic rise_d;
    logic fall_q;
    logic fall_d;

    // Next values
    always_comb
    begin
        rise_d = reset ? GIOC_DATA_RST : d;
        fall_d = reset ? GIOC_DATA_RST : d;
    end

    // Rising edge flop
    always_ff @(posedge clk)
    begin
        rise_q <= rise_d;
    end

    // Falling edge flop
    always_ff @(negedge clk)
    begin
        fall_q <= fall_d;
    end

    // Output select
    always_comb
    begin
        q = fall_sel ? fall_q : rise_q;
    end

endmodule : gioc_edge_reg

// ==== hw/gioc_dual_edge.sv ====
/*
 File: dual-edge register pair on one clock, capturing on both edges.
 Assumes: clk is the cell's input or output clock; reset is active high.
*/
`timescale 1ns/1ps
module gioc_dual_edge
    import gioc_pkg::*;
(
    input wire logic clk, // Clock for both edges
    input wire logic reset, // Synchronous reset, active high
    input wire logic d_rise, // Data captured on the rising edge
    input wire logic d_fall, // Data captured on the falling edge
    output logic q_rise, // Rising edge sample
    output logic q_fall // Falling edge sample
);

    // ------------------------------------------------------------
    // Edge flops
    // ------------------------------------------------------------
    logic rise_d;
    logic fall_d;

    // Next values
    always_comb
    begin
        rise_d = reset ? GIOC_DATA_RST : d_rise;
        fall_d = reset ? GIOC_DATA_RST : d_fall;
    end

    // Rising edge capture
    always_ff @(posedge clk)
    begin
        q_rise <= rise_d;
    end

    // Falling edge capture
    always_ff @(negedge clk)
    begin
        q_fall <= fall_d;
    end

endmodule : gioc_dual_edge

// ==== hw/gioc_cell.sv ====
/*
 File: the general-purpose pin logic cell between core fabric and pad.
 Assumes: configuration inputs are static in user mode; the pad wire is
 resolved outside from pad_out and pad_oe; pull codes go to the pad buffer.
*/
`timescale 1ns/1ps
module gioc_cell
    import gioc_pkg::*;
#(
    parameter bit DIFF_PIN_SINGLE_ENDED = 1'b0 // Pin borrowed from differential resources
)
(
    input wire logic mclk, // Cell reference clock, unused by data paths
    input wire logic reset, // Synchronous reset, active high
    input wire logic in_clk, // Input register clock
    input wire logic out_clk, // Output and enable register clock
    input wire logic core_clk, // Core clock tree for clock output
    input wire gioc_pkg::gioc_mode_e mode, // Pin mode
    input wire logic configuring, // Device is being configured
    input wire logic unused_pull_down, // Unused pin pulls down instead of up, unless borrowed from differential resources
    input wire logic in_reg_en, // Register the input path
    input wire logic in_fall_sel, // Input register on falling edge
    input wire logic out_reg_en, // Register the output path
    input wire logic out_fall_sel, // Output register on falling edge
    input wire logic oe_reg_en, // Register the output enable
    input wire logic oe_fall_sel, // Enable register on falling edge
    input wire logic out_invert, // Invert the single-edge registered output
    input wire logic dual_edge_io, // Dual-edge mode request
    input wire logic dual_edge_resync, // Present both bits on rising edge
    input wire logic core_out_rise_bit, // Core output bit, rising edge
    input wire logic core_out_fall_bit, // Core output bit, falling edge
    input wire logic core_oe, // Core output enable
    input wire logic pad_in, // Pad level seen by the input buffer
    output logic core_in_rise_bit, // Core input bit zero
    output logic core_in_fall_bit, // Core input bit one
    output logic alt_in, // Alternate input to other blocks
    output logic pad_out, // Pad driver data
    output logic pad_oe, // Pad driver enable, high drives
    output logic [1:0] pad_pull // Weak pull code to the pad
);
    import gioc_pkg::*;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic in_path_en;
    logic out_path_en;
    logic dual_edge_io_ok;
    assign in_path_en = (mode == GIOC_MODE_INPUT) || (mode == GIOC_MODE_BIDIR);
    assign out_path_en = (mode == GIOC_MODE_OUTPUT) || (mode == GIOC_MODE_BIDIR);
    assign dual_edge_io_ok = dual_edge_io && !DIFF_PIN_SINGLE_ENDED;

    // ------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------
    logic in_sdr_q;
    logic in_rise_q;
    logic in_fall_q;

    // Single-edge input register, own edge option
    gioc_edge_reg u_in_reg (
        .clk(in_clk),
        .reset(reset),
        .fall_sel(in_fall_sel),
        .d(pad_in),
        .q(in_sdr_q)
    );

    // Dual-edge input pair on the input clock
    gioc_dual_edge u_in_ddr (
        .clk(in_clk),
        .reset(reset),
        .d_rise(pad_in),
        .d_fall(pad_in),
        .q_rise(in_rise_q),
        .q_fall(in_fall_q)
    );

    // Resync: carry the fall sample to the next rising edge
    logic in_fall_rs_q;
    logic in_fall_rs_d;
    logic in_rise_rs_q;
    logic in_rise_rs_d;
    always_comb
    begin
        in_fall_rs_d = reset ? GIOC_DATA_RST : in_fall_q;
        in_rise_rs_d = reset ? GIOC_DATA_RST : in_rise_q;
    end

    // Both resync bits launch on the rising edge
    always_ff @(posedge in_clk)
    begin
        in_fall_rs_q <= in_fall_rs_d;
        in_rise_rs_q <= in_rise_rs_d;
    end

    // Core input bits; pad still observed when driver is off
    logic in_bit0;
    logic in_bit1;
    always_comb
    begin
        in_bit0 = GIOC_DATA_RST;
        in_bit1 = GIOC_DATA_RST;
        if (in_path_en)
        begin
            if (dual_edge_io_ok && dual_edge_resync)
            begin
                in_bit0 = in_rise_rs_q;
                in_bit1 = in_fall_rs_q;
            end
            else if (dual_edge_io_ok)
            begin
                in_bit0 = in_rise_q;
                in_bit1 = in_fall_q;
            end
            else
            begin
                in_bit0 = in_reg_en ? in_sdr_q : pad_in;
            end
        end
    end

    // Alternate path, never registered
    always_comb
    begin
        alt_in = (mode == GIOC_MODE_INPUT) ? pad_in : GIOC_DATA_RST;
    end

    // Output bits pass straight from the selected source
    always_comb
    begin
        core_in_rise_bit = in_bit0;
        core_in_fall_bit = in_bit1;
    end

    // ------------------------------------------------------------
    // Output and enable path
    // ------------------------------------------------------------
    logic out_sdr_q;
    logic oe_q;
    logic out_rise_q;
    logic out_fall_q;

    // Single-edge output register
    gioc_edge_reg u_out_reg (
        .clk(out_clk),
        .reset(reset),
        .fall_sel(out_fall_sel),
        .d(core_out_rise_bit),
        .q(out_sdr_q)
    );

    // Output enable register on the output clock
    gioc_edge_reg u_oe_reg (
        .clk(out_clk),
        .reset(reset),
        .fall_sel(oe_fall_sel),
        .d(core_oe),
        .q(oe_q)
    );

    // Dual-edge output pair on the output clock
    gioc_dual_edge u_out_ddr (
        .clk(out_clk),
        .reset(reset),
        .d_rise(core_out_rise_bit),
        .d_fall(core_out_fall_bit),
        .q_rise(out_rise_q),
        .q_fall(out_fall_q)
    );

    // Data and enable to the pad driver
    logic out_data;
    logic oe_val;
    always_comb
    begin
        out_data = GIOC_DATA_RST;
        oe_val = GIOC_OE_RST;
        if (mode == GIOC_MODE_CLKOUT)
        begin
            out_data = core_clk;
            oe_val = 1'b1;
        end
        else if (out_path_en)
        begin
            if (dual_edge_io_ok)
            begin
                out_data = out_clk ? out_rise_q : out_fall_q;
            end
            else if (out_reg_en)
            begin
                out_data = out_sdr_q ^ out_invert;
            end
            else
            begin
                out_data = core_out_rise_bit;
            end
            if (mode == GIOC_MODE_OUTPUT)
            begin
                oe_val = 1'b1;
            end
            else
            begin
                oe_val = oe_reg_en ? oe_q : core_oe;
            end
        end
        if (configuring)
        begin
            oe_val = GIOC_OE_RST;
        end
    end

    // Pad driver; floats whenever the enable is low
    always_comb
    begin
        pad_oe = oe_val;
        pad_out = oe_val ? out_data : GIOC_DATA_RST;
    end

    // ------------------------------------------------------------
    // Pull control
    // ------------------------------------------------------------
    always_comb
    begin
        pad_pull = GIOC_PULL_NONE;
        if (configuring)
        begin
            pad_pull = DIFF_PIN_SINGLE_ENDED ? GIOC_PULL_NONE : GIOC_PULL_UP;
        end
        else if (mode == GIOC_MODE_UNUSED)
        begin
            pad_pull = (unused_pull_down && !DIFF_PIN_SINGLE_ENDED) ? GIOC_PULL_DOWN
                                                                   : GIOC_PULL_UP;
        end
    end

endmodule : gioc_cell

// ==== verification/gioc_pad_model.sv ====
/*
 File: board wire at the pad of the pin logic cell.
 Assumes: the cell drives the wire only while pad_oe is high.
*/
`timescale 1ns/1ps
module gioc_pad_model
    import gioc_pkg::*;
(
    input wire logic pad_out, // Cell driver data
    input wire logic pad_oe, // Cell driver enable
    input wire logic [1:0] pad_pull, // Cell weak pull
    input wire logic board_en, // Board drives the wire
    input wire logic board_level, // Board drive level
    output logic pad_in // Resolved wire level
);
    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    // A floating wire shows the inverse of the current pad_out value
    always_comb
    begin
        if (pad_oe)
            pad_in = pad_out;
        else if (board_en)
            pad_in = board_level;
        else if (pad_pull == GIOC_PULL_UP)
            pad_in = 1'b1;
        else if (pad_pull == GIOC_PULL_DOWN)
            pad_in = 1'b0;
        else
            pad_in = ~pad_out;
    end
endmodule : gioc_pad_model

// ==== verification/gioc_cell_chk.sv ====
/*
 File: port checker of the pin logic cell.
 Assumes: in_clk and out_clk run in step with mclk.
*/
`timescale 1ns/1ps
module gioc_cell_chk
    import gioc_pkg::*;
#(
    parameter bit DIFF_PIN_SINGLE_ENDED = 1'b0 // Differential pin
)
(
    input wire logic mclk, // Clock
    input wire logic reset, // Reset
    input wire gioc_pkg::gioc_mode_e mode, // Mode
    input wire logic configuring, // Configuring
    input wire logic unused_pull_down, // Pull choice
    input wire logic in_reg_en, // Input reg
    input wire logic in_fall_sel, // Input edge
    input wire logic out_reg_en, // Output reg
    input wire logic out_fall_sel, // Output edge
    input wire logic oe_reg_en, // Enable reg
    input wire logic out_invert, // Invert
    input wire logic dual_edge_io, // Dual edge
    input wire logic core_out_rise_bit, // Core data
    input wire logic core_oe, // Core enable
    input wire logic pad_in, // Pad level
    input wire logic core_in_rise_bit, // Core input
    input wire logic alt_in, // Alternate input
    input wire logic pad_out, // Pad data
    input wire logic pad_oe, // Pad enable
    input wire logic [1:0] pad_pull // Pull code
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // Steady registered rising-edge set-ups
    wire in_r = mode == GIOC_MODE_INPUT && in_reg_en && !in_fall_sel && !dual_edge_io;
    wire out_r = !configuring && mode == GIOC_MODE_OUTPUT && out_reg_en && !out_fall_sel
        && !dual_edge_io;
    alt_pass_a: assert property (mode == GIOC_MODE_INPUT |-> alt_in == pad_in)
        else $error("alternate input differs from pad");
    in_direct_a: assert property (mode == GIOC_MODE_INPUT && !in_reg_en && !dual_edge_io
        |-> core_in_rise_bit == pad_in) else $error("direct input differs from pad");
    in_reg_a: assert property (in_r ##1 in_r |-> core_in_rise_bit == $past(pad_in))
        else $error("registered input wrong");
    out_reg_a: assert property (out_r ##1 out_r
        |-> pad_out == ($past(core_out_rise_bit) ^ out_invert)) else $error("output reg wrong");
    out_drive_a: assert property (!configuring && mode == GIOC_MODE_OUTPUT
        |-> pad_oe && pad_pull == GIOC_PULL_NONE) else $error("output not driven");
    oe_direct_a: assert property (!configuring && mode == GIOC_MODE_BIDIR && !oe_reg_en
        |-> pad_oe == core_oe) else $error("enable differs");
    cfg_pull_a: assert property (configuring && !DIFF_PIN_SINGLE_ENDED
        |-> !pad_oe && pad_pull == GIOC_PULL_UP) else $error("config pull wrong");
    unused_pull_a: assert property (!configuring && mode == GIOC_MODE_UNUSED |-> !pad_oe
        && pad_pull == (unused_pull_down ? GIOC_PULL_DOWN : GIOC_PULL_UP))
        else $error("unused pull wrong");
endmodule : gioc_cell_chk
bind gioc_cell gioc_cell_chk #(.DIFF_PIN_SINGLE_ENDED(DIFF_PIN_SINGLE_ENDED)) i_chk (.*);

// ==== verification/gioc_cell_tb.sv ====
/*
 File: self-checking bench of the pin logic cell.
 Assumes: all cell clocks are tied to mclk.
*/
`timescale 1ns/1ps
module gioc_cell_tb;
    import gioc_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    gioc_mode_e mode = GIOC_MODE_UNUSED;
    logic cfg = 1'b0, upd = 1'b0, ire = 1'b0, ifs = 1'b0, ore = 1'b0, ofs = 1'b0, oere = 1'b0;
    logic inv = 1'b0, ddr = 1'b0, rsy = 1'b0, orb = 1'b0, ofb = 1'b0, coe = 1'b0;
    logic ben = 1'b0, blev = 1'b0;
    logic pad_in, cin_r, cin_f, alt, pout, poe;
    logic [1:0] pull;
    int err_count = 0;
    int n_checks = 0;
    // ------------------------------------------------------------
    // Clock, cell and board
    // ------------------------------------------------------------
    always #25 mclk = ~mclk;
    gioc_cell i_dut (.mclk(mclk), .reset(reset), .in_clk(mclk), .out_clk(mclk), .core_clk(mclk),
        .mode(mode), .configuring(cfg), .unused_pull_down(upd), .in_reg_en(ire),
        .in_fall_sel(ifs), .out_reg_en(ore), .out_fall_sel(ofs), .oe_reg_en(oere),
        .oe_fall_sel(1'b0), .out_invert(inv), .dual_edge_io(ddr), .dual_edge_resync(rsy),
        .core_out_rise_bit(orb), .core_out_fall_bit(ofb), .core_oe(coe), .pad_in(pad_in),
        .core_in_rise_bit(cin_r), .core_in_fall_bit(cin_f), .alt_in(alt), .pad_out(pout),
        .pad_oe(poe), .pad_pull(pull));
    gioc_pad_model i_pad (.pad_out(pout), .pad_oe(poe), .pad_pull(pull), .board_en(ben),
        .board_level(blev), .pad_in(pad_in));
    // Compare and count
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // Verdict and end of run
    task automatic final_report();
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_pulls();
        for (int p = 0; p < 2; p++)
        begin
            upd <= p[0];
            tick(1);
            #10;
            chk(pull, p[0] ? GIOC_PULL_DOWN : GIOC_PULL_UP);
            chk(pad_in, !p[0]);
            tick(1);
        end
        cfg <= 1'b1;
        mode <= GIOC_MODE_OUTPUT;
        tick(1);
        #10;
        chk(poe, 1'b0);
        chk(pull, GIOC_PULL_UP);
        tick(1);
        cfg <= 1'b0;
    endtask : t_pulls
    task automatic t_input();
        mode <= GIOC_MODE_INPUT;
        ben <= 1'b1;
        blev <= 1'b1;
        tick(1);
        #10;
        chk(cin_r, 1'b1);
        chk(alt, 1'b1);
        for (int f = 0; f < 2; f++)
        begin
            tick(1);
            ire <= 1'b1;
            ifs <= f[0];
            blev <= 1'b0;
            tick(2);
            blev <= 1'b1;
            #10;
            chk(cin_r, 1'b0);
            #20;
            chk(cin_r, f[0]);
        end
        tick(1);
        ifs <= 1'b0;
    endtask : t_input
    // Rise sample 0, fall sample 1; resync shows both after the next rising edge
    task automatic t_ddr_in(input logic rs);
        ddr <= 1'b1;
        rsy <= rs;
        blev <= 1'b0;
        tick(1);
        blev <= 1'b1;
        if (!rs)
        begin
            #30;
            chk(cin_r, 1'b0);
            chk(cin_f, 1'b1);
        end
        else
        begin
            tick(1);
            #10;
            chk(cin_r, 1'b0);
            chk(cin_f, 1'b1);
        end
        tick(1);
        ddr <= 1'b0;
        tick(1);
    endtask : t_ddr_in
    task automatic t_out(input logic i);
        mode <= GIOC_MODE_OUTPUT;
        ben <= 1'b0;
        ore <= 1'b1;
        inv <= i;
        orb <= 1'b0;
        tick(2);
        orb <= 1'b1;
        #10;
        chk(pout, i);
        chk(poe, 1'b1);
        tick(1);
        #10;
        chk(pout, !i);
        tick(1);
    endtask : t_out
    task automatic t_ddr_out();
        ddr <= 1'b1;
        ore <= 1'b0;
        ofb <= 1'b0;
        tick(3);
        #10;
        chk(pout, 1'b1);
        #25;
        chk(pout, 1'b0);
        tick(1);
        ddr <= 1'b0;
    endtask : t_ddr_out
    task automatic t_bidir();
        mode <= GIOC_MODE_BIDIR;
        ire <= 1'b0;
        tick(2);
        oere <= 1'b1;
        tick(1);
        coe <= 1'b1;
        #10;
        chk(poe, 1'b0);
        tick(1);
        #10;
        chk(poe, 1'b1);
        chk(pout, 1'b1);
        tick(1);
        coe <= 1'b0;
        ben <= 1'b1;
        blev <= 1'b0;
        tick(2);
        #10;
        chk(poe, 1'b0);
        chk(cin_r, 1'b0);
        tick(1);
        mode <= GIOC_MODE_CLKOUT;
        tick(2);
        #10;
        chk(pout, 1'b1);
        chk(poe, 1'b1);
        #25;
        chk(pout, 1'b0);
    endtask : t_bidir
    // Main sequence
    initial
    begin
        tick(12);
        reset <= 1'b0;
        tick(2);
        t_pulls();
        t_input();
        t_ddr_in(1'b0);
        t_ddr_in(1'b1);
        t_out(1'b0);
        t_out(1'b1);
        t_ddr_out();
        t_bidir();
        final_report();
    end
    // Watchdog against a hang
    initial
    begin
        #20000;
        err_count++;
        final_report();
    end
endmodule : gioc_cell_tb
